/* File: logic/ifs_consts.vh */
`ifndef IFS_CONSTS_VH
`define IFS_CONSTS_VH

// ****************************************************************
// register byte addresses on the wishbone slave
// ****************************************************************
`define IFS_ADR_CPU_CONTROL   8'h00
`define IFS_ADR_FLAGS_0       8'h04
`define IFS_ADR_FLAGS_7       8'h08
`define IFS_ADR_ENABLE_0      8'h0C
`define IFS_ADR_ENABLE_7      8'h10
`define IFS_ADR_IRQ_STATUS    8'h14
`define IFS_ADR_IRQ_MASK      8'h18

// ****************************************************************
// field positions and widths
// ****************************************************************
`define IFS_CPU_PRIO_MSB_BIT  3
`define IFS_CPU_RSVD_BIT      2
`define IFS_PRIO_LOW_LIMIT    4'h7
`define IFS_FLAGS0_W          4
`define IFS_FLAGS7_W          6
`define IFS_IRQ_W             2
`define IFS_IRQ_BIT_F0        0
`define IFS_IRQ_BIT_F7        1

// ****************************************************************
// reset values
// ****************************************************************
`define IFS_FLAGS0_RST        4'h0
`define IFS_FLAGS7_RST        6'h00
`define IFS_IRQ_RST           2'h0

`endif

/* File: logic/ifs_flag_status.v */
// Operation
// RULE_01 - priority msb is one above level seven
// RULE_02 - level is msb over status bits 7..5
// RULE_03 - control bit two reads one
// RULE_04 - other control bits read zero
// RULE_05 - flag register 0 holds four source flags
// RULE_06 - flag register 7 holds six flags, upper zero
// RULE_07 - enable bit gates each flag to cpu
// RULE_08 - hardware set beats software zero clear
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "ifs_consts.vh"

module ifs_flag_status
(
  input  wire        i_ref_clk,
  input  wire        i_reset,
  // classic wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // cpu side
  input  wire [3:0]  i_cpu_priority_level,
  input  wire [2:0]  i_processor_status_reg_ipl,
  output reg  [3:0]  o_cpu_priority_level,
  output reg         o_cpu_priority_msb,
  output reg  [3:0]  o_flag_reg_0_req,
  output reg  [5:0]  o_flag_reg_7_req,
  // one-cycle source events, same clock
  input  wire        i_timer_one_event,
  input  wire        i_compare_one_event,
  input  wire        i_capture_one_event,
  input  wire        i_external_zero_event,
  input  wire        i_test_controller_event,
  input  wire        i_uart_six_error_event,
  input  wire        i_uart_six_transmit_event,
  input  wire        i_uart_six_receive_event,
  input  wire        i_uart_five_error_event,
  input  wire        i_uart_five_transmit_event,
  output reg         o_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg  [3:0]  flag_reg_0_q;
  reg  [5:0]  flag_reg_7_q;
  reg  [3:0]  enable_0_q;
  reg  [5:0]  enable_7_q;
  reg  [1:0]  irq_status_q;
  reg  [1:0]  irq_mask_q;
  reg         prio_msb_q;
  reg  [31:0] rd_data;

  wire        wr_req;
  wire        wr_lo;
  wire [3:0]  evt0;
  wire [5:0]  evt7;
  wire [3:0]  flag_reg_0_d;
  wire [5:0]  flag_reg_7_d;
  wire [1:0]  irq_event;
  wire [1:0]  irq_status_d;
  wire [3:0]  pend0;
  wire [5:0]  pend7;

  assign wr_req = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
  assign wr_lo  = wr_req & i_wb_sel[0];

  assign evt0 = {i_timer_one_event, i_compare_one_event,
                 i_capture_one_event, i_external_zero_event}; // RULE_05
  assign evt7 = {i_test_controller_event, i_uart_six_error_event,
                 i_uart_six_transmit_event, i_uart_six_receive_event,
                 i_uart_five_error_event,
                 i_uart_five_transmit_event}; // RULE_06

  // ****************************************************************
  // flag bits: software writes zero to clear, set wins
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `IFS_FLAGS0_W; g = g + 1)
    begin : gen_f0
      assign flag_reg_0_d[g] = evt0[g] | (flag_reg_0_q[g] &
        ~(wr_lo && i_wb_adr == `IFS_ADR_FLAGS_0 && !i_wb_dat[g])); // RULE_08
    end
    for (g = 0; g < `IFS_FLAGS7_W; g = g + 1)
    begin : gen_f7
      assign flag_reg_7_d[g] = evt7[g] | (flag_reg_7_q[g] &
        ~(wr_lo && i_wb_adr == `IFS_ADR_FLAGS_7 && !i_wb_dat[g])); // RULE_08
    end
  endgenerate

  assign pend0 = flag_reg_0_q & enable_0_q; // RULE_07
  assign pend7 = flag_reg_7_q & enable_7_q; // RULE_07

  // a sticky bit per register records that a new flag was raised
  assign irq_event = {|(evt7 & ~flag_reg_7_q), |(evt0 & ~flag_reg_0_q)};
  assign irq_status_d = irq_event | (irq_status_q &
    ~((wr_lo && i_wb_adr == `IFS_ADR_IRQ_STATUS) ?
      i_wb_dat[1:0] : `IFS_IRQ_RST));

  // ****************************************************************
  // registers
  // ****************************************************************
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      flag_reg_0_q <= `IFS_FLAGS0_RST;
      flag_reg_7_q <= `IFS_FLAGS7_RST;
      enable_0_q   <= `IFS_FLAGS0_RST;
      enable_7_q   <= `IFS_FLAGS7_RST;
      irq_status_q <= `IFS_IRQ_RST;
      irq_mask_q   <= `IFS_IRQ_RST;
      prio_msb_q   <= 1'b0;
    end
    else
    begin
      flag_reg_0_q <= flag_reg_0_d;
      flag_reg_7_q <= flag_reg_7_d;
      irq_status_q <= irq_status_d;
      prio_msb_q   <= (i_cpu_priority_level > `IFS_PRIO_LOW_LIMIT); // RULE_01
      if (wr_lo && i_wb_adr == `IFS_ADR_ENABLE_0)
        enable_0_q <= i_wb_dat[3:0];
      if (wr_lo && i_wb_adr == `IFS_ADR_ENABLE_7)
        enable_7_q <= i_wb_dat[5:0];
      if (wr_lo && i_wb_adr == `IFS_ADR_IRQ_MASK)
        irq_mask_q <= i_wb_dat[1:0];
    end
  end

  // ****************************************************************
  // read mux; unmapped addresses read zero and still ack
  // ****************************************************************
  always @*
  begin
    rd_data = 32'h0000_0000;
    case (i_wb_adr)
      `IFS_ADR_CPU_CONTROL:
      begin
        rd_data[`IFS_CPU_PRIO_MSB_BIT] = prio_msb_q; // RULE_01
        rd_data[`IFS_CPU_RSVD_BIT]     = 1'b1;       // RULE_03
      end                                           // RULE_04
      `IFS_ADR_FLAGS_0:    rd_data[3:0] = flag_reg_0_q; // RULE_05
      `IFS_ADR_FLAGS_7:    rd_data[5:0] = flag_reg_7_q; // RULE_06
      `IFS_ADR_ENABLE_0:   rd_data[3:0] = enable_0_q;
      `IFS_ADR_ENABLE_7:   rd_data[5:0] = enable_7_q;
      `IFS_ADR_IRQ_STATUS: rd_data[1:0] = irq_status_q;
      `IFS_ADR_IRQ_MASK:   rd_data[1:0] = irq_mask_q;
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // bus answer and outputs, all registered
  // ****************************************************************
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_wb_ack             <= 1'b0;
      o_wb_dat             <= 32'h0000_0000;
      o_irq                <= 1'b0;
      o_cpu_priority_level <= 4'h0;
      o_cpu_priority_msb   <= 1'b0;
      o_flag_reg_0_req     <= 4'h0;
      o_flag_reg_7_req     <= 6'h00;
    end
    else
    begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      o_wb_dat <= rd_data;
      o_irq    <= |(irq_status_q & irq_mask_q);
      o_cpu_priority_msb   <= prio_msb_q; // RULE_01
      o_cpu_priority_level <= {prio_msb_q,
                               i_processor_status_reg_ipl}; // RULE_02
      o_flag_reg_0_req     <= pend0; // RULE_07
      o_flag_reg_7_req     <= pend7; // RULE_07
    end
  end

endmodule

/* File: verif/ifs_checker.sv */
`timescale 1ns/100ps
// ****
// port checks
// ****
module ifs_checker (
  input wire        i_ref_clk,
  input wire        i_reset,
  input wire        i_wb_cyc,
  input wire        i_wb_stb,
  input wire        i_wb_we,
  input wire [7:0]  i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire        o_wb_ack,
  input wire [3:0]  i_cpu_priority_level,
  input wire [2:0]  i_processor_status_reg_ipl,
  input wire [3:0]  o_cpu_priority_level,
  input wire        o_cpu_priority_msb
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_msb_level: assert property (!$past(i_reset) && !$past(i_reset, 2)
    |-> o_cpu_priority_msb == ($past(i_cpu_priority_level, 2) > 4'h7))
    else $error("priority msb wrong");
  a_level_join: assert property (!$past(i_reset) && !$past(i_reset, 2)
    |-> o_cpu_priority_level ==
    {o_cpu_priority_msb, $past(i_processor_status_reg_ipl)})
    else $error("priority level wrong");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("ack late");
  a_ctl_read: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(i_wb_adr) == 8'h00 |->
    o_wb_dat == {28'h0, o_cpu_priority_msb, 3'h4})
    else $error("control read wrong");
  a_f0_upper: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(i_wb_adr) == 8'h04 |-> o_wb_dat[31:4] == 28'h0)
    else $error("flags0 upper bits set");
  a_f7_upper: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(i_wb_adr) == 8'h08 |-> o_wb_dat[31:6] == 26'h0)
    else $error("flags7 upper bits set");
  a_unmapped_zero: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(i_wb_adr) > 8'h18 |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
endmodule

/* File: verif/ifs_partner.sv */
`timescale 1ns/100ps
// ****
// event sources and cpu core
// ****
module ifs_partner (
  input  wire [9:0] i_fire,
  input  wire [3:0] i_level,
  output wire [9:0] o_event,
  output wire [2:0] o_ipl
);
  assign o_event = i_fire;
  // status bits 7..5 always track the low three bits of the core's own level
  assign o_ipl = i_level[2:0];
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
// ****
// bench
// ****
module tb_top;
  logic        clk, rst, cyc, stb, we, ack, msb, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q[$];
  logic [9:0]  fire, ev;
  logic [3:0]  lvl, olv, r0, sel;
  logic [2:0]  ipl;
  logic [5:0]  r7;
  int          err_total, n_tests, i, lv;
  ifs_partner PM (.i_fire(fire), .i_level(lvl), .o_event(ev), .o_ipl(ipl));
  ifs_flag_status DUT (.i_ref_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_cpu_priority_level(lvl), .i_processor_status_reg_ipl(ipl),
    .o_cpu_priority_level(olv), .o_cpu_priority_msb(msb),
    .o_flag_reg_0_req(r0), .o_flag_reg_7_req(r7),
    .i_timer_one_event(ev[3]), .i_compare_one_event(ev[2]),
    .i_capture_one_event(ev[1]), .i_external_zero_event(ev[0]),
    .i_test_controller_event(ev[9]), .i_uart_six_error_event(ev[8]),
    .i_uart_six_transmit_event(ev[7]), .i_uart_six_receive_event(ev[6]),
    .i_uart_five_error_event(ev[5]), .i_uart_five_transmit_event(ev[4]),
    .o_irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic give_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, v);
    n_tests++;
    if (v !== x)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, x, v);
    end
  endtask
  // on reads d is the expected word, noted before the request goes out
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    if (!w)
      q.push_back(d);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    wdat <= d;
    n = 0;
    // ack is read in the edge's time step, before the slave updates it
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      err_total++;
      give_verdict();
    end
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    fire <= v;
    @(posedge clk);
    fire <= 10'h000;
  endtask
  always @(negedge clk)
    if (ack === 1'b1 && we === 1'b0)
      chk("rd_data", q.pop_front(), rdat);
  initial
  begin
    {rst, cyc, stb, we} = 4'b1000;
    {adr, wdat, fire, lvl} = 0;
    sel = 4'hF;
    err_total = 0;
    n_tests = 0;
    void'($urandom(91));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(0, 8'h00, 32'h4);
    for (i = 0; i < 7; i++)
    begin
      lv = (i < 2) ? 7 + i : $urandom % 16;
      @(posedge clk);
      lvl <= lv[3:0];
      repeat (3) @(posedge clk);
      wb(0, 8'h00, {28'h0, lv > 7, 3'h4});
      chk("prio_level", lv, {28'h0, olv});
    end
    pulse(10'h3FF);
    wb(0, 8'h04, 32'hF);
    wb(0, 8'h08, 32'h3F);
    wb(0, 8'h1C, 32'h0);
    chk("req7", 0, {26'h0, r7});
    wb(1, 8'h10, 32'h21);
    repeat (3) @(posedge clk);
    chk("req7", 32'h21, {26'h0, r7});
    fork
      wb(1, 8'h04, 32'h0);
      pulse(10'h008);
    join
    wb(0, 8'h04, 32'h8);
    chk("req0", 0, {28'h0, r0});
    wb(1, 8'h0C, 32'h8);
    repeat (3) @(posedge clk);
    chk("req0", 32'h8, {28'h0, r0});
    // a write with byte lane zero off must leave the flags alone
    sel <= 4'h0;
    wb(1, 8'h04, 32'h0);
    sel <= 4'hF;
    wb(0, 8'h04, 32'h8);
    chk("irq", 0, {31'h0, irq});
    wb(1, 8'h18, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 1, {31'h0, irq});
    wb(1, 8'h14, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq", 0, {31'h0, irq});
    give_verdict();
  end
endmodule
bind ifs_flag_status ifs_checker u_chk (.*);
